//--- verilog/clr_pkg.sv
// Overview of operation
// - on switch-on, latch target light level as setpoint; hold it while on
// - step dim value until sensor matches setpoint; daylight supplements
// - status read returns setpoint percent and driven dim percent
// - hysteresis and switch-off delay act only when a relay is paired
// - relay drops only after delay elapses with no renewed light request
// - after drop, relay re-arms when shortfall exceeds hysteresis or on the manual switch
// - hysteresis is an integer from zero to nineteen
// - regulation starts only once the paired relay is on
// - key, scene and table commands act as dimmer and beat regulation
// - after a manual command, hold that level and suspend regulation
// - switching the output off clears the override
// - one-button and two-button modes; one-button is the reset default
// - setpoint is held as a light percentage, not as illuminance
// - one-button cycles zero-max-zero; two-button has separate up and down
// - held key ramps full range in 5.1 s; tap under 0.3 s runs in 2.5 s
package clr_pkg;

    // register byte offsets
    localparam logic [4:0] OFF_CTRL   = 5'h00;
    localparam logic [4:0] OFF_TARGET = 5'h04;
    localparam logic [4:0] OFF_HYST   = 5'h08;
    localparam logic [4:0] OFF_DELAY  = 5'h0C;
    localparam logic [4:0] OFF_STATUS = 5'h10;
    localparam logic [4:0] OFF_LEVEL  = 5'h14;

    // control field positions
    localparam int CTRL_ON     = 0;
    localparam int CTRL_TWOKEY = 1;
    localparam int CTRL_PAIRED = 2;

    // status field positions
    localparam int ST_SETPT    = 0;
    localparam int ST_DIM      = 8;
    localparam int ST_OVR      = 16;
    localparam int ST_RELAY    = 17;
    localparam int ST_REG      = 18;

    // value limits and reset values
    localparam logic [6:0]  LEVEL_MAX   = 7'h64;
    localparam logic [4:0]  HYST_MAX    = 5'h13;
    localparam logic [6:0]  TARGET_RST  = 7'h46;
    localparam logic [4:0]  HYST_RST    = 5'h00;
    localparam logic [15:0] DELAY_RST   = 16'h0032;

    // timing, in the unit printed, then in cycles
    localparam int CLK_KHZ      = 200_000;
    localparam int HOLD_RAMP_MS = 5100;
    localparam int FAST_RAMP_MS = 2500;
    localparam int SHORT_MS     = 300;
    localparam int TICK_MS      = 100;
    localparam int REG_MS       = 10;
    localparam int HOLD_STEP_CYC = CLK_KHZ * HOLD_RAMP_MS / 100;
    localparam int FAST_STEP_CYC = CLK_KHZ * FAST_RAMP_MS / 100;
    localparam int SHORT_CYC     = CLK_KHZ * SHORT_MS;
    localparam int TICK_CYC      = CLK_KHZ * TICK_MS;
    localparam int REG_CYC       = CLK_KHZ * REG_MS;

    typedef enum logic [1:0] {R_OFF, R_ON, R_HOLD, R_REARM} relay_t;
    typedef enum logic [1:0] {K_IDLE, K_PRESS, K_HOLD, K_RUN} key_t;

endpackage

//--- verilog/key_dimmer.sv
`timescale 1ns/1ps
module key_dimmer
    import clr_pkg::*;
#(
    parameter int unsigned SHORT_LEN = SHORT_CYC,
    parameter int unsigned HOLD_STEP = HOLD_STEP_CYC,
    parameter int unsigned FAST_STEP = FAST_STEP_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       two_key,
    input  wire logic       key_a,
    input  wire logic       key_b,
    input  wire logic [6:0] level_in,
    output logic            man_valid,
    output logic [6:0]      man_level
);

    typedef struct packed {
        key_t        mode;
        logic        dir;
        logic [6:0]  lvl;
        logic [31:0] cnt;
        logic        valid;
    } kstate_t;

    kstate_t s_reg;
    kstate_t s_next;
    logic    pressed;
    logic    at_end;
    logic    step;

    assign man_valid = s_reg.valid;
    assign man_level = s_reg.lvl;

    // one step toward the end point chosen by dir, never past it
    always_comb begin
        s_next       = s_reg;
        s_next.valid = 1'b0;
        pressed = two_key ? (key_a | key_b) : key_a;
        at_end  = s_reg.dir ? (s_reg.lvl >= LEVEL_MAX) : (s_reg.lvl == 7'h00);
        step    = 1'b0;
        unique case (s_reg.mode)
            K_IDLE: begin
                if (pressed) begin
                    s_next.mode = K_PRESS;
                    s_next.cnt  = 32'h0000_0000;
                    s_next.lvl  = level_in;
                    if (two_key) begin
                        s_next.dir = key_a;
                    end
                end
            end
            K_PRESS: begin
                // released before the short limit: run to the end point
                if (!pressed) begin
                    s_next.mode = K_RUN;
                    s_next.cnt  = 32'h0000_0000;
                end else if (s_reg.cnt == 32'(SHORT_LEN - 1)) begin
                    s_next.mode = K_HOLD;
                    s_next.cnt  = 32'h0000_0000;
                end else begin
                    s_next.cnt = s_reg.cnt + 32'h0000_0001;
                end
            end
            K_HOLD: begin
                if (!pressed) begin
                    s_next.mode = K_IDLE;
                    s_next.dir  = two_key ? s_reg.dir : !s_reg.dir;
                end else if (s_reg.cnt == 32'(HOLD_STEP - 1)) begin
                    s_next.cnt = 32'h0000_0000;
                    step       = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt + 32'h0000_0001;
                end
            end
            K_RUN: begin
                if (at_end) begin
                    s_next.mode = K_IDLE;
                    s_next.dir  = two_key ? s_reg.dir : !s_reg.dir;
                end else if (s_reg.cnt == 32'(FAST_STEP - 1)) begin
                    s_next.cnt = 32'h0000_0000;
                    step       = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt + 32'h0000_0001;
                end
            end
        endcase
        if (step) begin
            if (at_end) begin
                // one-button reverses at either end for a full cycle
                s_next.dir = two_key ? s_reg.dir : !s_reg.dir;
            end else begin
                s_next.lvl   = s_reg.dir ? s_reg.lvl + 7'h01
                                         : s_reg.lvl - 7'h01;
                s_next.valid = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_reg      <= '0;
            s_reg.mode <= K_IDLE;
            s_reg.dir  <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule

//--- verilog/constant_light_regulator.sv
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module constant_light_regulator
    import clr_pkg::*;
#(
    parameter int unsigned TICK_LEN  = TICK_CYC,
    parameter int unsigned REG_LEN   = REG_CYC,
    parameter int unsigned SHORT_LEN = SHORT_CYC,
    parameter int unsigned HOLD_STEP = HOLD_STEP_CYC,
    parameter int unsigned FAST_STEP = FAST_STEP_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [6:0]  sensor_level,
    input  wire logic        presence,
    input  wire logic        relay_manual,
    input  wire logic        key_a,
    input  wire logic        key_b,
    output logic [6:0]       dim_level,
    output logic             relay_on
);

    typedef struct packed {
        logic        out_on;
        logic        two_key;
        logic        paired;
        logic [6:0]  target;
        logic [6:0]  setpoint;
        logic [6:0]  dim;
        logic [4:0]  hyst;
        logic [15:0] delay;
        logic        override;
        logic        was_on;
        relay_t      rstate;
        logic        relay;
        logic [15:0] dcnt;
        logic [31:0] tick_cnt;
        logic [31:0] reg_cnt;
        logic        tick;
        logic        reg_tick;
        logic        waitreq;
        logic [31:0] rdata;
    } state_t;

    state_t      s_reg;
    state_t      s_next;
    logic [31:0] rd_mux;
    logic        commit;
    logic        regulate;
    logic        want_light;
    logic [7:0]  sensor_hyst;
    logic        man_valid;
    logic [6:0]  man_level;

    // key handling runs beside the register file and hands back levels
    key_dimmer #(
        .SHORT_LEN (SHORT_LEN),
        .HOLD_STEP (HOLD_STEP),
        .FAST_STEP (FAST_STEP)
    ) u_keys (
        .core_clk  (core_clk),
        .srst      (srst),
        .two_key   (s_reg.two_key),
        .key_a     (key_a),
        .key_b     (key_b),
        .level_in  (s_reg.dim),
        .man_valid (man_valid),
        .man_level (man_level)
    );

    assign avs_readdata    = s_reg.rdata;
    assign avs_waitrequest = s_reg.waitreq;
    assign dim_level       = s_reg.dim;
    assign relay_on        = s_reg.relay;

    // saturate any written level into 0..100 percent
    function automatic logic [6:0] sat_level(input logic [31:0] v);
        sat_level = (v > 32'(LEVEL_MAX)) ? LEVEL_MAX : v[6:0];
    endfunction

    // read mux; unmapped offsets read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            OFF_CTRL: begin
                rd_mux[CTRL_ON]     = s_reg.out_on;
                rd_mux[CTRL_TWOKEY] = s_reg.two_key;
                rd_mux[CTRL_PAIRED] = s_reg.paired;
            end
            OFF_TARGET: rd_mux[6:0]  = s_reg.target;
            OFF_HYST:   rd_mux[4:0]  = s_reg.hyst;
            OFF_DELAY:  rd_mux[15:0] = s_reg.delay;
            OFF_STATUS: begin
                rd_mux[ST_SETPT +: 7] = s_reg.setpoint;
                rd_mux[ST_DIM +: 7]   = s_reg.dim;
                rd_mux[ST_OVR]        = s_reg.override;
                rd_mux[ST_RELAY]      = s_reg.relay;
                rd_mux[ST_REG]        = regulate;
            end
            OFF_LEVEL:  rd_mux[6:0] = s_reg.dim;
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    // regulation only with output on, no override and, if paired, relay on
    assign regulate = s_reg.out_on && !s_reg.override
                      && (!s_reg.paired || s_reg.relay);

    // light is wanted while dimmed up or while the room is too dark
    assign want_light = s_reg.out_on
                        && ((s_reg.dim != 7'h00)
                            || (!s_reg.override
                                && sensor_level < s_reg.setpoint));

    // re-arm threshold: sensor plus hysteresis, one bit wider
    assign sensor_hyst = {1'b0, sensor_level} + {3'b000, s_reg.hyst};

    // a write commits only at the edge where waitrequest is seen low
    assign commit = avs_write && !s_reg.waitreq;

    always_comb begin
        s_next          = s_reg;
        s_next.tick     = 1'b0;
        s_next.reg_tick = 1'b0;

        // delay-off timebase and regulation timebase
        if (s_reg.tick_cnt == 32'(TICK_LEN - 1)) begin
            s_next.tick_cnt = 32'h0000_0000;
            s_next.tick     = 1'b1;
        end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 32'h0000_0001;
        end
        if (s_reg.reg_cnt == 32'(REG_LEN - 1)) begin
            s_next.reg_cnt  = 32'h0000_0000;
            s_next.reg_tick = 1'b1;
        end else begin
            s_next.reg_cnt = s_reg.reg_cnt + 32'h0000_0001;
        end

        // bus answer: one wait cycle, then waitrequest low for one cycle
        if ((avs_read || avs_write) && s_reg.waitreq) begin
            s_next.waitreq = 1'b0;
            s_next.rdata   = rd_mux;
        end else begin
            s_next.waitreq = 1'b1;
        end

        // automatic regulation, one percent per regulation tick
        if (regulate && s_reg.reg_tick) begin
            if (sensor_level < s_reg.setpoint
                && s_reg.dim < LEVEL_MAX) begin
                s_next.dim = s_reg.dim + 7'h01;
            end else if (sensor_level > s_reg.setpoint
                         && s_reg.dim != 7'h00) begin
                s_next.dim = s_reg.dim - 7'h01;
            end
        end else if (s_reg.paired && !s_reg.relay
                     && !s_reg.override) begin
            // no point driving a ballast whose supply is open
            s_next.dim = 7'h00;
        end

        // key commands act like an ordinary dimmer and win
        if (man_valid) begin
            s_next.dim      = man_level;
            s_next.override = 1'b1;
            s_next.out_on   = 1'b1;
        end

        // register writes; unmapped offsets are ignored
        if (commit) begin
            unique case (avs_address)
                OFF_CTRL: begin
                    s_next.out_on  = avs_writedata[CTRL_ON];
                    s_next.two_key = avs_writedata[CTRL_TWOKEY];
                    s_next.paired  = avs_writedata[CTRL_PAIRED];
                end
                OFF_TARGET: begin
                    s_next.target = sat_level(avs_writedata);
                end
                OFF_HYST: begin
                    s_next.hyst = (avs_writedata > 32'(HYST_MAX))
                                  ? HYST_MAX
                                  : avs_writedata[4:0];
                end
                OFF_DELAY: s_next.delay = avs_writedata[15:0];
                OFF_LEVEL: begin
                    // a key step in this cycle is replaced by the written level
                    // scene or control table level; zero means off
                    s_next.dim      = sat_level(avs_writedata);
                    s_next.override = 1'b1;
                    s_next.out_on   = (avs_writedata != 32'h0000_0000);
                end
                default: begin
                    // status and unmapped offsets leave all state alone
                end
            endcase
        end

        // switch-on latches the setpoint; switch-off ends the override
        if (s_next.out_on && !s_reg.was_on) begin
            s_next.setpoint = s_reg.target;
        end
        if (!s_next.out_on) begin
            s_next.override = 1'b0;
            s_next.dim      = 7'h00;
        end
        s_next.was_on = s_next.out_on;

        // relay coordination, only meaningful with a paired relay
        if (!s_reg.paired) begin
            s_next.rstate = R_OFF;
            s_next.relay  = 1'b0;
            s_next.dcnt   = 16'h0000;
        end else begin
            unique case (s_reg.rstate)
                R_OFF: begin
                    if (s_reg.out_on && (presence || relay_manual)) begin
                        s_next.rstate = R_ON;
                        s_next.relay  = 1'b1;
                    end
                end
                R_ON: begin
                    if (!want_light) begin
                        s_next.rstate = R_HOLD;
                        s_next.dcnt   = 16'h0000;
                    end
                end
                R_HOLD: begin
                    // a renewed request restarts the whole delay
                    if (want_light) begin
                        s_next.rstate = R_ON;
                    end else if (s_reg.tick) begin
                        if (s_reg.dcnt >= s_reg.delay) begin
                            s_next.rstate = R_REARM;
                            s_next.relay  = 1'b0;
                        end else begin
                            s_next.dcnt = s_reg.dcnt + 16'h0001;
                        end
                    end
                end
                R_REARM: begin
                    // hysteresis keeps a flickering sensor from cycling
                    if (!s_reg.out_on) begin
                        s_next.rstate = R_OFF;
                    end else if (relay_manual
                                 || sensor_hyst < {1'b0, s_reg.setpoint}) begin
                        s_next.rstate = R_ON;
                        s_next.relay  = 1'b1;
                    end
                end
            endcase
        end
    end

    // all state in one register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_reg         <= '0;
            s_reg.target  <= TARGET_RST;
            s_reg.hyst    <= HYST_RST;
            s_reg.delay   <= DELAY_RST;
            s_reg.rstate  <= R_OFF;
            s_reg.waitreq <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule

//--- tb/clr_asserts.sv
`timescale 1ns/1ps
module clr_asserts
    import clr_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [6:0]  dim_level,
    input wire logic        relay_on
);
    logic       wr_ok;
    logic       rd_ok;
    logic [6:0] lvl_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // accepted transfers; low bits of the last accepted write of any offset kept for a later compare
    assign wr_ok = avs_write && !avs_waitrequest;
    assign rd_ok = avs_read && !avs_waitrequest;
    always_ff @(posedge core_clk) begin
        lvl_reg <= wr_ok ? avs_writedata[6:0] : lvl_reg;
    end

    // one wait cycle, then a one-cycle answer
    a_wait_one: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_wait_once: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("answer held longer than one cycle");
    a_unmapped_zero: assert property (
        rd_ok && avs_address > OFF_LEVEL |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_hyst_range: assert property (
        rd_ok && avs_address == OFF_HYST |-> avs_readdata <= 32'h0000_0013)
        else $error("hysteresis read above nineteen");
    // level in range, and only single steps unless the bus commanded
    a_dim_clamp: assert property (
        dim_level <= LEVEL_MAX)
        else $error("dim level above one hundred");
    a_dim_step: assert property (
        !$past(avs_write) && !$past(avs_write, 2) |->
        dim_level == $past(dim_level) || dim_level == $past(dim_level) + 7'h01
        || dim_level + 7'h01 == $past(dim_level))
        else $error("dim level jumped without a bus command");
    a_relay_drop: assert property (
        $fell(relay_on) |-> $past(dim_level) == 7'h00)
        else $error("relay dropped while light was driven");
    a_off_clear: assert property (
        wr_ok && avs_address == OFF_CTRL && !avs_writedata[0]
        |-> ##[1:2] dim_level == 7'h00)
        else $error("output off did not clear dim level");
    a_level_set: assert property (
        wr_ok && avs_address == OFF_LEVEL && avs_writedata <= 32'h0000_0064
        |-> ##[1:2] dim_level == lvl_reg)
        else $error("manual level not driven");

    c_relay_drop: cover property ($fell(relay_on));
    c_full_level: cover property (dim_level == LEVEL_MAX);
    c_level_set: cover property (wr_ok && avs_address == OFF_LEVEL);
endmodule

bind constant_light_regulator clr_asserts chk (
    .core_clk(core_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dim_level(dim_level),
    .relay_on(relay_on)
);

//--- tb/home_controller.sv
`timescale 1ns/1ps
module home_controller (
    input  wire logic        core_clk,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    output logic [4:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata
);
    // idle bus at time zero
    initial begin
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
    end

    // call just after an edge; request held till waitrequest seen low
    task automatic xfer(input logic wr, input logic [4:0] a,
                        input logic [31:0] dat, output logic [31:0] rdat);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= dat;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a; // released lines must not look still valid
        avs_writedata <= ~dat;
        @(posedge core_clk);
    endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import clr_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] SM  = 32'h0005_7F7F;

    logic        core_clk, srst, presence, relay_manual, key_a, key_b;
    logic        avs_read, avs_write, avs_waitrequest, relay_on;
    logic [4:0]  avs_address;
    logic [6:0]  sensor_level, dim_level;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [31:0] seed = 32'h0000_000D;
    int          miscompares, checks, day, d, t, e;

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // room: daylight plus our own light reaches the sensor
    always @(posedge core_clk) begin
        sensor_level <= (day + dim_level > 100) ? 7'h64 : 7'(day + dim_level);
    end

    // short counts keep the run brief
    constant_light_regulator #(
        .TICK_LEN(10), .REG_LEN(4), .SHORT_LEN(20), .HOLD_STEP(3),
        .FAST_STEP(2)
    ) dut (
        .core_clk(core_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sensor_level(sensor_level),
        .presence(presence), .relay_manual(relay_manual), .key_a(key_a),
        .key_b(key_b), .dim_level(dim_level), .relay_on(relay_on)
    );
    home_controller ctl (
        .core_clk(core_clk), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] stat(int sp, int dm, int ov, int rg);
        return 32'((rg << 18) | (ov << 16) | (dm << 8) | sp);
    endfunction
    task automatic chk(string n, logic [31:0] ex, logic [31:0] got);
        checks++;
        if (got !== ex) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, ex, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(logic [4:0] a, int v);
        ctl.xfer(1'b1, a, 32'(v), q);
    endtask
    task automatic rd(logic [4:0] a, logic [31:0] m, logic [31:0] ex);
        ctl.xfer(1'b0, a, 32'h0000_0000, q);
        chk($sformatf("reg %h", a), ex, q & m);
    endtask
    task automatic push(int b, int n);
        key_a <= (b == 0);
        key_b <= (b == 1);
        cyc(n);
        key_a <= 1'b0;
        key_b <= 1'b0;
    endtask
    task automatic final_report();
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        {srst, presence, relay_manual, key_a, key_b} = 5'h10;
        day = 100;
        cyc(16);
        srst <= 1'b0;
        cyc(1);
        // reset values, unmapped read, clamped writes
        rd(OFF_CTRL, ALL, 0);
        rd(OFF_TARGET, ALL, 70);
        rd(OFF_DELAY, ALL, 50);
        rd(5'h18, ALL, 0);
        wr(OFF_TARGET, 127);
        rd(OFF_TARGET, ALL, 100);
        wr(OFF_HYST, 25);
        rd(OFF_HYST, ALL, 19);
        // random target and daylight; loop must settle on the shortfall
        repeat (3) begin
            t = int'(rnd() % 101);
            d = int'(rnd() % 101);
            e = (d < t) ? t - d : 0;
            day <= d;
            wr(OFF_CTRL, 0);
            wr(OFF_TARGET, t);
            wr(OFF_CTRL, 1);
            cyc(500);
            chk("dim", e, dim_level);
            rd(OFF_STATUS, SM, stat(t, e, 0, 1));
        end
        wr(OFF_TARGET, t / 2);
        cyc(100);
        rd(OFF_STATUS, SM, stat(t, e, 0, 1));
        wr(OFF_LEVEL, 30);
        cyc(100);
        rd(OFF_STATUS, SM, stat(t, 30, 1, 0));
        wr(OFF_CTRL, 0);
        rd(OFF_STATUS, 32'h0001_7F00, 0);
        wr(OFF_CTRL, 1);
        cyc(500);
        e = (d < t / 2) ? t / 2 - d : 0;
        rd(OFF_STATUS, SM, stat(t / 2, e, 0, 1));
        // keys: one-button taps go up then down, two-button hold ramps
        wr(OFF_CTRL, 0);
        for (int i = 0; i < 2; i++) begin
            push(0, 5);
            cyc(260);
            chk("tap", (i == 0) ? 100 : 0, dim_level);
        end
        wr(OFF_CTRL, 3);
        push(0, 50);
        cyc(5);
        chk("ramp", 1, dim_level >= 8 && dim_level <= 12);
        push(1, 5);
        cyc(60);
        chk("down", 0, dim_level);
        // paired relay: start on presence, delayed drop, hysteresis re-arm
        wr(OFF_CTRL, 0);
        wr(OFF_HYST, 5);
        wr(OFF_DELAY, 3);
        wr(OFF_TARGET, 60);
        day <= 30;
        wr(OFF_CTRL, 5);
        cyc(50);
        chk("relay", 0, {dim_level, relay_on});
        presence <= 1'b1;
        cyc(1);
        presence <= 1'b0;
        cyc(500);
        chk("relay", {7'd30, 1'b1}, {dim_level, relay_on});
        day <= 90;
        for (int i = 0; i < 400 && dim_level != 0; i++) cyc(1);
        cyc(15);
        chk("hold", 1, relay_on);
        cyc(40);
        chk("drop", 0, relay_on);
        day <= 56;
        cyc(60);
        chk("rearm", 0, relay_on);
        day <= 54;
        cyc(30);
        chk("rearm", 1, relay_on);
        // bright room again, then the manual switch brings the relay back
        day <= 90;
        cyc(120);
        chk("drop", 0, relay_on);
        relay_manual <= 1'b1;
        cyc(1);
        relay_manual <= 1'b0;
        cyc(3);
        chk("manual", 1, relay_on);
        final_report();
    end

    // hang guard well beyond the expected run
    initial begin
        cyc(30000);
        miscompares++;
        final_report();
    end
endmodule
